// >>> include/adc_port_defs.vh
// Constants for the conversion result output port
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`ifndef ADC_PORT_DEFS_VH
`define ADC_PORT_DEFS_VH

// -----------------------------------------------------------------------------
// Widths and buffering
// -----------------------------------------------------------------------------
`define RES_W 16
`define FIFO_DEPTH 8
`define FIFO_AW 3

// -----------------------------------------------------------------------------
// Register map and fields
// -----------------------------------------------------------------------------
`define REG_AW 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_EN_BIT 0
`define CTRL_RST 1'b1
`define ST_PAR_VALID_BIT 0
`define ST_FRAME_BIT 1
`define ST_SERIAL_BIT 2
`define ST_COUNT_LSB 4

// -----------------------------------------------------------------------------
// Shared pin positions in serial mode
// -----------------------------------------------------------------------------
`define PIN_DIV_LO 2
`define PIN_DIV_HI 3
`define PIN_EXT 4
`define PIN_SYNC_POL 5
`define PIN_INV 6
`define PIN_RDC 7
`define PIN_SDO 8
`define PIN_SCLK 9
`define PIN_SYNC 10

// -----------------------------------------------------------------------------
// Internal serial clock timing
// -----------------------------------------------------------------------------
`define MCLK_NS 10
`define SCLK_PER0_NS 25
`define SCLK_PER1_NS 50
`define SCLK_PER2_NS 100
`define SCLK_PER3_NS 200
// Least period rounds up to whole mclk cycles
`define NS_TO_CYC(ns) (((ns) + `MCLK_NS - 1) / `MCLK_NS)
`define CYC_W 5

`endif

// >>> hw/result_fifo.v
// Result word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  // Fill level
  output reg [AW:0] count_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  wire push;
  wire pop;

  // Full and empty follow the level counter
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_q];

  // Storage has no reset; only the pointers and the level counter need a defined value
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which may be any size up to 2**AW
  always @(posedge mclk) begin
    if (!resetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // result_fifo

// >>> hw/serial_clk_gen.v
// Internal serial clock generator with selectable period
`include "adc_port_defs.vh"
`timescale 1ns/1ps
module serial_clk_gen (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Control
  input wire run,
  input wire [1:0] per_sel,
  // Generated clock
  output wire sclk_int,
  output wire fall_tick
);

  reg [`CYC_W-1:0] cnt_q;
  wire [`CYC_W-1:0] per;
  wire [`CYC_W-1:0] low_len;

  // Period in mclk cycles for each divide code
  // Cycle counts are worked out as integers and cut to the counter width on purpose
  function [`CYC_W-1:0] period_cyc;
    input [1:0] sel;
    integer cyc;
    begin
      case (sel)
        2'h0: cyc = `NS_TO_CYC(`SCLK_PER0_NS);
        2'h1: cyc = `NS_TO_CYC(`SCLK_PER1_NS);
        2'h2: cyc = `NS_TO_CYC(`SCLK_PER2_NS);
        default: cyc = `NS_TO_CYC(`SCLK_PER3_NS);
      endcase
      period_cyc = cyc[`CYC_W-1:0];
    end
  endfunction

  assign per = period_cyc(per_sel);
  // Low phase is the shorter half so the high phase never drops below spec
  assign low_len = per >> 1;
  assign sclk_int = run & (cnt_q >= low_len);
  assign fall_tick = run & (cnt_q == per - 1'b1);

  // Counter idles at zero so every frame starts with a full low phase
  always @(posedge mclk) begin
    if (!resetn || !run) begin
      cnt_q <= {`CYC_W{1'b0}};
    end else if (cnt_q == per - 1'b1) begin
      cnt_q <= {`CYC_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // serial_clk_gen

// >>> hw/result_output_port.v
// Conversion result output port: parallel bus or serial port on shared pins
`include "adc_port_defs.vh"
`timescale 1ns/1ps
module result_output_port (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Results from the conversion engine
  input wire [`RES_W-1:0] result_data,
  input wire result_valid,
  output wire result_ready,
  input wire conv_busy,
  // Static mode straps
  input wire byte_order_sel,
  input wire coding_sel,
  input wire interface_sel,
  // Shared data pins
  input wire [`RES_W-1:0] d_in,
  output reg [`RES_W-1:0] d_out_q,
  output reg [`RES_W-1:0] d_oe_q,
  // Parallel handshake with the host
  output wire par_valid,
  input wire par_ack,
  // Register port
  input wire [`REG_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  reg state_q;
  reg [`RES_W-1:0] shift_q;
  reg [3:0] bits_q;
  reg ext_sclk_q;
  reg [`RES_W-1:0] par_q;
  reg par_valid_q;
  reg en_q;
  reg [`RES_W-1:0] pin_d;
  reg [`RES_W-1:0] oe_d;

  wire [`RES_W-1:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire [`FIFO_AW:0] fifo_count;
  wire serial_mode;
  wire ext_clk;
  wire sync_pol;
  wire sclk_inv;
  wire rdc;
  wire chain_in;
  wire [1:0] div_code;
  wire read_after;
  wire [1:0] per_sel;
  wire sclk_int;
  wire fall_tick;
  wire ext_rise;
  wire ext_fall;
  wire update;
  wire start;
  wire par_load;
  wire last_bit;

  // ---------------------------------------------------------------------------
  // Mode decode from straps and shared pins
  // ---------------------------------------------------------------------------
  // Coding applied to a word: top bit flipped for two's complement
  function [`RES_W-1:0] code_word;
    input [`RES_W-1:0] w;
    input straight;
    begin
      code_word = {w[`RES_W-1] ^ ~straight, w[`RES_W-2:0]};
    end
  endfunction

  assign serial_mode = interface_sel;
  // Serial configuration pins are only meaningful as inputs in serial mode
  assign ext_clk = d_in[`PIN_EXT];
  assign sync_pol = d_in[`PIN_SYNC_POL];
  assign sclk_inv = d_in[`PIN_INV];
  assign rdc = d_in[`PIN_RDC];
  assign chain_in = d_in[`PIN_RDC];
  assign div_code = d_in[`PIN_DIV_HI:`PIN_DIV_LO];
  // Master read-after-convert is the only mode that honours the divider
  assign read_after = serial_mode & ~ext_clk & ~rdc;
  assign per_sel = read_after ? div_code : 2'h0;

  // ---------------------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------------------
  result_fifo #(
    .WIDTH(`RES_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data(result_data),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .count_q(fifo_count)
  );

  // ---------------------------------------------------------------------------
  // Serial clocking
  // ---------------------------------------------------------------------------
  serial_clk_gen u_clk (
    .mclk(mclk),
    .resetn(resetn),
    .run((state_q == ST_SHIFT) & ~ext_clk),
    .per_sel(per_sel),
    .sclk_int(sclk_int),
    .fall_tick(fall_tick)
  );

  // Host clock is taken as a synchronous input; remember last level for edges
  always @(posedge mclk) begin
    if (!resetn) begin
      ext_sclk_q <= 1'b0;
    end else begin
      ext_sclk_q <= d_in[`PIN_SCLK];
    end
  end

  assign ext_rise = d_in[`PIN_SCLK] & ~ext_sclk_q;
  assign ext_fall = ~d_in[`PIN_SCLK] & ext_sclk_q;
  // Update edge of the host clock follows the invert pin
  assign update = ext_clk ? (sclk_inv ? ext_fall : ext_rise) : fall_tick;
  assign last_bit = (bits_q == 4'hf);

  // ---------------------------------------------------------------------------
  // Serial frame sequencer
  // ---------------------------------------------------------------------------
  // Read-during-convert and host-clocked frames may start while busy; internal-clock read-after waits for idle
  assign start = (state_q == ST_IDLE) & serial_mode & en_q & fifo_valid &
    (ext_clk | rdc | ~conv_busy);
  assign par_load = ~serial_mode & en_q & fifo_valid & (~par_valid_q | par_ack);
  assign fifo_pop = start | par_load;

  // Word is shifted out top bit first; host chain data fills from below
  always @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      shift_q <= {`RES_W{1'b0}};
      bits_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_SHIFT;
            shift_q <= code_word(fifo_data, coding_sel);
            bits_q <= 4'h0;
          end
        end
        ST_SHIFT: begin
          if (update) begin
            shift_q <= {shift_q[`RES_W-2:0], ext_clk & chain_in};
            bits_q <= bits_q + 4'h1;
            if (last_bit) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Parallel holding register
  // ---------------------------------------------------------------------------
  // A new load in the same cycle as the host's acknowledge keeps valid set
  always @(posedge mclk) begin
    if (!resetn) begin
      par_q <= {`RES_W{1'b0}};
      par_valid_q <= 1'b0;
    end else if (par_load) begin
      par_q <= code_word(fifo_data, coding_sel);
      par_valid_q <= 1'b1;
    end else if (par_ack || serial_mode) begin
      par_valid_q <= 1'b0;
    end
  end

  assign par_valid = par_valid_q;

  // ---------------------------------------------------------------------------
  // Pin multiplexing
  // ---------------------------------------------------------------------------
  // Next values for the registered pins; outputs lag the sequencer one cycle
  always @* begin
    pin_d = {`RES_W{1'b0}};
    oe_d = {`RES_W{1'b0}};
    if (!serial_mode) begin
      // All pins, including the shared ones, carry result bits
      oe_d = {`RES_W{1'b1}};
      if (byte_order_sel) begin
        pin_d = {par_q[7:0], par_q[15:8]};
      end else begin
        pin_d = par_q;
      end
    end else begin
      // Bits 0 and 1 float; configuration pins stay inputs
      oe_d[1:0] = 2'b00;
      oe_d[`PIN_SDO] = 1'b1;
      oe_d[`PIN_SYNC] = 1'b1;
      oe_d[`PIN_SCLK] = ~ext_clk;
      pin_d[`PIN_SDO] = (state_q == ST_SHIFT) & shift_q[`RES_W-1];
      pin_d[`PIN_SCLK] = sclk_int ^ sclk_inv;
      pin_d[`PIN_SYNC] = (state_q == ST_SHIFT) ^ sync_pol;
    end
  end

  // Pins come straight from flops to keep glitches off the host's clock
  always @(posedge mclk) begin
    if (!resetn) begin
      d_out_q <= {`RES_W{1'b0}};
      d_oe_q <= {`RES_W{1'b0}};
    end else begin
      d_out_q <= pin_d;
      d_oe_q <= oe_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  // Clearing enable lets a frame in flight finish; only new words are held back
  always @(posedge mclk) begin
    if (!resetn) begin
      en_q <= `CTRL_RST;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      en_q <= reg_wdata[`CTRL_EN_BIT];
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero
  always @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL: begin
            reg_rdata_q[`CTRL_EN_BIT] <= en_q;
          end
          `REG_STATUS: begin
            reg_rdata_q[`ST_PAR_VALID_BIT] <= par_valid_q;
            reg_rdata_q[`ST_FRAME_BIT] <= (state_q == ST_SHIFT);
            reg_rdata_q[`ST_SERIAL_BIT] <= serial_mode;
            reg_rdata_q[`ST_COUNT_LSB +: `FIFO_AW+1] <= fifo_count;
          end
          default: begin
            reg_rdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // result_output_port

// >>> testbench/result_port_properties.sv
// Assertions on the result output port pins and register port
`timescale 1ns/1ps
`include "adc_port_defs.vh"
module result_port_properties (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Pins and parallel handshake
  input wire interface_sel,
  input wire [`RES_W-1:0] d_in,
  input wire [`RES_W-1:0] d_out_q,
  input wire [`RES_W-1:0] d_oe_q,
  input wire par_valid,
  input wire par_ack,
  // Register port
  input wire [`REG_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q
);
  reg pol_q;
  reg ser_q;
  // Sync pin is judged against the polarity in force when it was launched
  always @(posedge mclk) begin
    pol_q <= d_in[`PIN_SYNC_POL];
    ser_q <= interface_sel;
  end
  wire sync_act = interface_sel & ser_q & (d_out_q[`PIN_SYNC] ^ pol_q);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_ctrl_write;
    reg_wr && reg_addr == `REG_CTRL;
  endsequence
  sequence s_ctrl_read;
    reg_rd && reg_addr == `REG_CTRL;
  endsequence
  sequence s_frame_start;
    $rose(sync_act);
  endsequence
  chk_ctrl_readback: assert property (s_ctrl_write ##1 s_ctrl_read |=>
    reg_rdata_q[`CTRL_EN_BIT] == $past(reg_wdata[`CTRL_EN_BIT], 2)) else $error("ctrl readback");
  chk_status_mode: assert property (reg_rd && reg_addr == `REG_STATUS |=>
    reg_rdata_q[`ST_SERIAL_BIT] == $past(interface_sel)) else $error("status mode bit");
  chk_unmapped_read: assert property (reg_rd && reg_addr != `REG_CTRL &&
    reg_addr != `REG_STATUS |=> reg_rdata_q == 32'h0) else $error("unmapped read");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0) else $error("rdata idle");
  chk_float_pins: assert property (interface_sel [*2] |->
    d_oe_q[1:0] == 2'b00 && d_oe_q[15:11] == 5'h00) else $error("serial float pins");
  chk_serial_drive: assert property (interface_sel [*2] ##0 $stable(d_in[`PIN_EXT]) |->
    d_oe_q[`PIN_SDO] && d_oe_q[`PIN_SYNC] && d_oe_q[`PIN_SCLK] == !d_in[`PIN_EXT])
    else $error("serial drive");
  chk_par_drive: assert property (!interface_sel [*2] ##0 par_valid |->
    d_oe_q == 16'hffff) else $error("parallel drive");
  chk_frame_hold: assert property (s_frame_start |-> sync_act [*8])
    else $error("frame sync short");
  chk_par_hold: assert property (par_valid && $past(par_valid) && !par_ack &&
    !$past(par_ack) && !interface_sel |=> par_valid && $stable(d_out_q)) else $error("par hold");
endmodule // result_port_properties
bind result_output_port result_port_properties i_props (.mclk(mclk), .resetn(resetn),
  .interface_sel(interface_sel), .d_in(d_in), .d_out_q(d_out_q), .d_oe_q(d_oe_q),
  .par_valid(par_valid), .par_ack(par_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

// >>> testbench/host_model.sv
// Host side model: sets the shared strap pins, takes parallel words, reads serial frames
`timescale 1ns/1ps
`include "adc_port_defs.vh"
module host_model (
  // Clock
  input wire mclk,
  // Pins and parallel handshake
  input wire [15:0] d_out_q,
  input wire [15:0] d_oe_q,
  output wire [15:0] d_in,
  input wire par_valid,
  output logic par_ack,
  // Host settings
  input wire cfg_ser,
  input wire [1:0] cfg_div,
  input wire cfg_ext,
  input wire cfg_pol,
  input wire cfg_inv,
  input wire cfg_rdc,
  input wire [3:0] ack_wait
);
  logic [15:0] words[$];
  logic [15:0] sh_word = 16'h0;
  logic [31:0] last_per = 32'h0;
  logic [31:0] per_cnt = 32'h0;
  logic [7:0] noise = 8'h0;
  logic [4:0] nbits = 5'h0;
  logic [3:0] pcnt = 4'h0;
  logic [1:0] hcnt = 2'h0;
  logic hsck = 1'b1;
  logic sck_q = 1'b0;
  logic act_q = 1'b0;
  // Frame sync and clock seen through their polarity straps
  wire act = cfg_ser & (d_out_q[`PIN_SYNC] ^ cfg_pol);
  wire sck_n = cfg_ext ? hsck : (d_out_q[`PIN_SCLK] ^ cfg_inv);
  // Undriven pins carry straps or a changing pattern, so a stale level never passes
  wire [15:0] host_pins = {noise[6:2], noise[1], hsck ^ cfg_inv, noise[0], cfg_rdc, cfg_inv,
    cfg_pol, cfg_ext, cfg_div, noise[1:0]};
  assign d_in = (d_oe_q & d_out_q) | (~d_oe_q & host_pins);
  initial par_ack = 1'b0;
  // Parallel take after a programmable wait, serial capture in both clock modes
  always @(posedge mclk) begin
    noise <= noise + 8'h01;
    act_q <= act;
    sck_q <= sck_n;
    per_cnt <= per_cnt + 32'h1;
    if (par_ack) begin
      par_ack <= 1'b0;
      pcnt <= 4'h0;
    end else if (par_valid && !cfg_ser) begin
      if (pcnt >= ack_wait) begin
        words.push_back(d_out_q);
        par_ack <= 1'b1;
      end else begin
        pcnt <= pcnt + 4'h1;
      end
    end
    if (!act) begin
      if (act_q && nbits == 5'd16) words.push_back(sh_word);
      nbits <= 5'd0;
      hsck <= 1'b1;
      hcnt <= 2'd0;
    end else if (cfg_ext) begin
      // Host clock runs only inside a frame; bits are taken on its falling edge
      hcnt <= hcnt + 2'd1;
      if (hcnt == 2'd2) begin
        hcnt <= 2'd0;
        if (hsck && nbits < 5'd16) begin
          hsck <= 1'b0;
          sh_word <= {sh_word[14:0], d_out_q[`PIN_SDO]};
          nbits <= nbits + 5'd1;
        end else if (!hsck) begin
          hsck <= 1'b1;
        end
      end
    end else if (sck_n && !sck_q) begin
      sh_word <= {sh_word[14:0], d_out_q[`PIN_SDO]};
      nbits <= nbits + 5'd1;
      last_per <= per_cnt;
      per_cnt <= 32'h1;
    end
  end
endmodule // host_model

// >>> testbench/testbench.sv
// Self-checking bench for the result output port
`timescale 1ns/1ps
`include "adc_port_defs.vh"
module testbench;
  logic mclk, resetn, result_valid, conv_busy, byte_order_sel, coding_sel, interface_sel;
  logic reg_wr, reg_rd, par_valid, par_ack, result_ready, cfg_ext, cfg_pol, cfg_inv, cfg_rdc;
  logic [15:0] result_data, d_in, d_out_q, d_oe_q, w;
  logic [3:0] reg_addr, ack_wait;
  logic [31:0] reg_wdata, reg_rdata_q, rd;
  logic [1:0] cfg_div;
  int err_count, n_tests, k, nw;
  always #5 mclk = ~mclk;
  result_output_port i_dut (.mclk(mclk), .resetn(resetn), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready), .conv_busy(conv_busy),
    .byte_order_sel(byte_order_sel), .coding_sel(coding_sel), .interface_sel(interface_sel),
    .d_in(d_in), .d_out_q(d_out_q), .d_oe_q(d_oe_q), .par_valid(par_valid), .par_ack(par_ack),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q));
  host_model i_host (.mclk(mclk), .d_out_q(d_out_q), .d_oe_q(d_oe_q), .d_in(d_in),
    .par_valid(par_valid), .par_ack(par_ack), .cfg_ser(interface_sel), .cfg_div(cfg_div),
    .cfg_ext(cfg_ext), .cfg_pol(cfg_pol), .cfg_inv(cfg_inv), .cfg_rdc(cfg_rdc),
    .ack_wait(ack_wait));
  // Expected pin word: coding on the top bit, then optional byte swap
  function automatic logic [31:0] expw(input logic [15:0] v, input logic bin, input logic sw);
    logic [15:0] c;
    c = bin ? v : {~v[15], v[14:0]};
    return {16'h0, sw ? {c[7:0], c[15:8]} : c};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus tasks start just after a rising edge and end on one
  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Take the read data while they stand, not at the edge that clears them
    #1;
    v = reg_rdata_q;
    @(posedge mclk);
  endtask
  // Valid stays up between words so a burst never lowers and raises it at one edge
  task automatic push(input logic [15:0] v, input logic last);
    result_data <= v;
    result_valid <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk);
      if (result_ready === 1'b1) break;
    end
    if (last) result_valid <= 1'b0;
  endtask
  task automatic wait_words(input int n);
    for (int i = 0; i < 3000 && i_host.words.size() < n; i++) @(posedge mclk);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard: far above the thousand or so cycles the sequence needs
  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    {mclk, resetn, result_valid, conv_busy, byte_order_sel, interface_sel} = 6'h00;
    {reg_wr, reg_rd, cfg_div, cfg_ext, cfg_pol, cfg_inv} = 7'h00;
    {coding_sel, cfg_rdc, ack_wait, reg_addr, reg_wdata, result_data} = 58'h0;
    err_count = 0;
    n_tests = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    reg_read(`REG_CTRL, rd);
    cmp(rd, 32'h1);
    reg_write(4'h8, 32'hffff_ffff);
    reg_read(4'h8, rd);
    cmp(rd, 32'h0);
    reg_read(`REG_STATUS, rd);
    cmp(rd, 32'h0);
    // Parallel: every coding and byte order, host fast then slow
    for (k = 0; k < 4; k++) begin
      {coding_sel, byte_order_sel} <= 2'(k);
      ack_wait <= 4'(k * 3 + 1);
      w = 16'h5a3c ^ 16'(k * 16'h1111);
      push(w, 1'b1);
      wait_words(k + 1);
      cmp({16'h0, i_host.words[k]}, expw(w, k[1], k[0]));
    end
    // Fill the buffer while loads are disabled, then drain it
    reg_write(`REG_CTRL, 32'h0);
    reg_read(`REG_CTRL, rd);
    cmp(rd, 32'h0);
    for (k = 0; k < 8; k++) push(16'h0f10 + 16'(k), k == 7);
    @(posedge mclk);
    cmp({31'h0, result_ready}, 32'h0);
    reg_read(`REG_STATUS, rd);
    cmp(rd, 32'h80);
    reg_write(`REG_CTRL, 32'h1);
    wait_words(12);
    for (k = 0; k < 8; k++) cmp({16'h0, i_host.words[4 + k]}, expw(16'h0f10 + 16'(k), 1, 1));
    // Serial, internal clock: read after conversion per divide code, then during conversion
    interface_sel <= 1'b1;
    byte_order_sel <= 1'b0;
    repeat (2) @(posedge mclk);
    reg_read(`REG_STATUS, rd);
    cmp(rd, 32'h4);
    for (k = 0; k < 5; k++) begin
      cfg_div <= (k == 4) ? 2'd3 : 2'(k);
      cfg_rdc <= (k == 4);
      {cfg_inv, cfg_pol} <= 2'(k);
      coding_sel <= k[0];
      conv_busy <= 1'b1;
      nw = i_host.words.size();
      w = 16'hc381 + 16'(k);
      push(w, 1'b1);
      repeat (40) @(posedge mclk);
      if (k < 4) cmp(32'(i_host.words.size()), 32'(nw));
      conv_busy <= 1'b0;
      wait_words(nw + 1);
      cmp({16'h0, i_host.words[nw]}, expw(w, k[0], 1'b0));
      cmp(i_host.last_per, `NS_TO_CYC(`SCLK_PER0_NS << (k % 4)));
    end
    // Serial, host clock in both clock senses; straps settle before each frame
    cfg_ext <= 1'b1;
    for (k = 0; k < 2; k++) begin
      {cfg_inv, cfg_pol} <= 2'(k + 1);
      repeat (4) @(posedge mclk);
      nw = i_host.words.size();
      w = 16'h96e1 ^ 16'(k);
      push(w, 1'b1);
      wait_words(nw + 1);
      cmp({16'h0, i_host.words[nw]}, expw(w, coding_sel, 1'b0));
    end
    tally_and_finish;
  end
endmodule // testbench
